/* File: rtl/fam_map.vh */
// What this block does
// - In 3-byte mode the extended address byte supplies address bits 31..24.
// - Read-extended-address returns that byte MSB first on falling clock edges.
// - Write-extended-address with one data byte is taken only when latch set.
// - Extended address byte clears to zero at power up and software reset.
// - In 4-byte mode every address overwrites the extended address byte.
// - Enter-4-byte opcode ended by chip select high selects 32-bit addresses.
// - Exit-4-byte opcode returns to 24-bit addresses plus extended byte.
// - Enter-quad opcode works only with quad enable set, else ignored.
// - Power-up is standard mode; standard and quad modes never coexist.
// - Mode switching keeps write latch, suspend and wrap setting unchanged.
// - Exit-quad opcode returns the device to standard mode.
// - Reset happens only when reset-enable is directly followed by reset.
// - Software reset aborts work and clears all volatile settings.
// - After reset opcode, about 300 us busy, every instruction rejected.
// - Normal read takes a 3 or 4 byte address, data out on falling edges.
// - Read advances address each byte and streams until chip select rises.
// - Reads are rejected while a program, erase or status write runs.
// - Read with 32-bit address always takes a full 32-bit address.
// - Read with 32-bit address is recognised only in standard mode.
// - Fast read adds a dummy byte (16 dummy bits in quad mode), then streams with auto-increment.
// - Write enable sets the latch; instructions needing it refused when clear.
`ifndef FAM_MAP_VH
`define FAM_MAP_VH
`define FAM_OP_WREN 8'h06
`define FAM_OP_WRDI 8'h04
`define FAM_OP_RDEXT 8'hC8
`define FAM_OP_WREXT 8'hC5
`define FAM_OP_EN4B 8'hB7
`define FAM_OP_EX4B 8'hE9
`define FAM_OP_EQPI 8'h38
`define FAM_OP_XQPI 8'hFF
`define FAM_OP_RSTEN 8'h66
`define FAM_OP_RST 8'h99
`define FAM_OP_READ 8'h03
`define FAM_OP_READ4 8'h13
`define FAM_OP_FREAD 8'h0B
`define FAM_BITS_OP 6'h08
`define FAM_BITS_A3 6'h18
`define FAM_BITS_A4 6'h20
`define FAM_BITS_DMY_STD 6'h08
`define FAM_BITS_DMY_QUAD 6'h10
`define FAM_EXT_RST 8'h00
`define FAM_ADS_RST 1'b0
`define FAM_T_RST_US 300
`define FAM_CLK_MHZ 25
`endif

/* File: rtl/fam_flash_front.v */
`timescale 1ns/1ps
`include "fam_map.vh"
module fam_flash_front #(
    parameter RST_CYC = `FAM_T_RST_US * `FAM_CLK_MHZ,
    parameter RST_W = 14
) (
    input wire ref_clk,
    input wire rst_n,
    input wire sclk,
    input wire csN,
    input wire [3:0] ioIn,
    output reg [3:0] ioOut,
    output reg [3:0] ioOe,
    output reg [31:0] memAddr,
    output reg memRead,
    input wire [7:0] memData,
    input wire quadEnableBit,
    input wire operationInProgress,
    input wire welClear,
    input wire wrapLoad,
    input wire [2:0] wrapIn,
    input wire modeBitsLoad,
    input wire [7:0] modeBitsIn,
    output reg writeEnableLatch,
    output reg addressWidthStatus,
    output reg quadCommandMode,
    output reg [7:0] extAddrByte,
    output reg [2:0] wrapSettingBits,
    output reg [7:0] continuousReadModeBits,
    output reg softResetPulse,
    output wire resetBusy
);

localparam S_IDLE = 7'h01;
localparam S_CMD = 7'h02;
localparam S_ADDR = 7'h04;
localparam S_DUMMY = 7'h08;
localparam S_DATA = 7'h10;
localparam S_WDAT = 7'h20;
localparam S_HOLD = 7'h40;
// Counter load cut to its width on purpose; RST_W must cover RST_CYC
localparam [RST_W-1:0] RST_LOAD = RST_CYC[RST_W-1:0];

// Frame phases:
// S_CMD collects the opcode,
// S_ADDR the 24 or 32 address bits,
// S_DUMMY the fast read gap,
// S_DATA streams bytes out on falling edges,
// S_WDAT takes the one data byte of the extended byte write,
// S_HOLD waits for chip select to end the frame.
// Single-byte commands act only at chip select rise,
// so a cut or overlong frame changes no state except the reset-enable arming.

reg sclkS1_r, sclkS2_r, sclkS3_r;
reg csS1_r, csS2_r, csS3_r;
reg [3:0] ioS1_r, ioS2_r;
reg [6:0] state_r;
reg [31:0] sh_r;
reg [5:0] cnt_r;
reg [7:0] op_r;
reg pendOk_r;
reg need32_r;
reg fast_r;
reg rdExt_r;
reg armed_r;
reg pendRst_r;
reg [7:0] outSh_r;
reg [2:0] outCnt_r;
reg [RST_W-1:0] rstCnt_r;

// Edges found from the second and third stage only;
// the first stage may still be metastable.
// Link clock must stay slow against ref_clk (half period >= 4 cycles).
wire sRise = sclkS2_r & ~sclkS3_r;
wire sFall = ~sclkS2_r & sclkS3_r;
wire csRise = csS2_r & ~csS3_r;
wire csLow = ~csS2_r;
// Quad mode moves a nibble per clock, standard one bit
wire [31:0] shNx = quadCommandMode ? {sh_r[27:0], ioS2_r} :
    {sh_r[30:0], ioS2_r[0]};
wire [5:0] cntNx = cnt_r + (quadCommandMode ? 6'h04 : 6'h01);
wire [5:0] addrBits = need32_r ? `FAM_BITS_A4 : `FAM_BITS_A3;
wire [5:0] dmyBits = quadCommandMode ? `FAM_BITS_DMY_QUAD :
    `FAM_BITS_DMY_STD;
wire [7:0] byteV = (outCnt_r != 3'h0) ? outSh_r :
    (rdExt_r ? extAddrByte : memData);

assign resetBusy = (rstCnt_r != {RST_W{1'b0}});

// Next nibble or bit to shift out, MSB first
function [3:0] laneBits;
    input quad;
    input [7:0] b;
    begin
        laneBits = quad ? b[7:4] : {2'b00, b[7], 1'b0};
    end
endfunction

// Idle levels as reset values avoid a false edge after reset
always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
        sclkS1_r <= 1'b0;
        sclkS2_r <= 1'b0;
        sclkS3_r <= 1'b0;
        csS1_r <= 1'b1;
        csS2_r <= 1'b1;
        csS3_r <= 1'b1;
        ioS1_r <= 4'h0;
        ioS2_r <= 4'h0;
    end else begin
        sclkS1_r <= sclk;
        sclkS2_r <= sclkS1_r;
        sclkS3_r <= sclkS2_r;
        csS1_r <= csN;
        csS2_r <= csS1_r;
        csS3_r <= csS2_r;
        ioS1_r <= ioIn;
        ioS2_r <= ioS1_r;
    end
end

always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
        state_r <= S_IDLE;
        sh_r <= 32'h0;
        cnt_r <= 6'h0;
        op_r <= 8'h0;
        pendOk_r <= 1'b0;
        need32_r <= 1'b0;
        fast_r <= 1'b0;
        rdExt_r <= 1'b0;
        armed_r <= 1'b0;
        pendRst_r <= 1'b0;
        outSh_r <= 8'h0;
        outCnt_r <= 3'h0;
        rstCnt_r <= {RST_W{1'b0}};
        ioOut <= 4'h0;
        ioOe <= 4'h0;
        memAddr <= 32'h0;
        memRead <= 1'b0;
        writeEnableLatch <= 1'b0;
        addressWidthStatus <= `FAM_ADS_RST;
        quadCommandMode <= 1'b0;
        extAddrByte <= `FAM_EXT_RST;
        wrapSettingBits <= 3'h0;
        continuousReadModeBits <= 8'h0;
        softResetPulse <= 1'b0;
    end else begin
        softResetPulse <= 1'b0;
        // Busy counter runs down to zero, then frames are taken again
        if (resetBusy)
            rstCnt_r <= rstCnt_r - {{(RST_W-1){1'b0}}, 1'b1};
        // Clear from other logic first so a same-cycle set wins
        if (welClear)
            writeEnableLatch <= 1'b0;
        if (wrapLoad)
            wrapSettingBits <= wrapIn;
        if (modeBitsLoad)
            continuousReadModeBits <= modeBitsIn;
        if (csRise) begin
            state_r <= S_IDLE;
            ioOe <= 4'h0;
            memRead <= 1'b0;
            if (state_r == S_WDAT && cnt_r == `FAM_BITS_OP)
                extAddrByte <= sh_r[7:0];
            if (state_r == S_HOLD && pendOk_r) begin
                // Mode changes leave latch, suspend and wrap alone
                case (op_r)
                    `FAM_OP_WREN: writeEnableLatch <= 1'b1;
                    `FAM_OP_WRDI: writeEnableLatch <= 1'b0;
                    `FAM_OP_EN4B: addressWidthStatus <= 1'b1;
                    `FAM_OP_EX4B: addressWidthStatus <= 1'b0;
                    `FAM_OP_EQPI: begin
                        if (quadEnableBit)
                            quadCommandMode <= 1'b1;
                    end
                    `FAM_OP_XQPI: quadCommandMode <= 1'b0;
                    `FAM_OP_RST: begin
                        if (pendRst_r) begin
                            // Volatile state back to power-on values
                            writeEnableLatch <= 1'b0;
                            addressWidthStatus <= `FAM_ADS_RST;
                            quadCommandMode <= 1'b0;
                            extAddrByte <= `FAM_EXT_RST;
                            wrapSettingBits <= 3'h0;
                            continuousReadModeBits <= 8'h0;
                            softResetPulse <= 1'b1;
                            rstCnt_r <= RST_LOAD;
                            armed_r <= 1'b0;
                        end
                    end
                    default: ;
                endcase
            end
        end else if (csLow && state_r == S_IDLE) begin
            // While resetting, whole frames are swallowed
            state_r <= resetBusy ? S_HOLD : S_CMD;
            pendOk_r <= 1'b0;
            cnt_r <= 6'h0;
            sh_r <= 32'h0;
            outCnt_r <= 3'h0;
            rdExt_r <= 1'b0;
        end else if (sRise) begin
            case (state_r)
                S_CMD: begin
                    sh_r <= shNx;
                    cnt_r <= cntNx;
                    if (cntNx == `FAM_BITS_OP) begin
                        op_r <= shNx[7:0];
                        cnt_r <= 6'h0;
                        pendOk_r <= 1'b0;
                        state_r <= S_HOLD;
                        // Any opcode but reset-enable disarms the pair
                        armed_r <= (shNx[7:0] == `FAM_OP_RSTEN);
                        pendRst_r <= armed_r &&
                            (shNx[7:0] == `FAM_OP_RST);
                        case (shNx[7:0])
                            `FAM_OP_READ, `FAM_OP_FREAD: begin
                                if (!operationInProgress)
                                    state_r <= S_ADDR;
                                need32_r <= addressWidthStatus;
                                fast_r <= (shNx[7:0] == `FAM_OP_FREAD);
                            end
                            `FAM_OP_READ4: begin
                                if (!operationInProgress &&
                                    !quadCommandMode)
                                    state_r <= S_ADDR;
                                need32_r <= 1'b1;
                                fast_r <= 1'b0;
                            end
                            `FAM_OP_RDEXT: begin
                                state_r <= S_DATA;
                                rdExt_r <= 1'b1;
                            end
                            `FAM_OP_WREXT: begin
                                if (writeEnableLatch)
                                    state_r <= S_WDAT;
                            end
                            `FAM_OP_WREN, `FAM_OP_WRDI, `FAM_OP_EN4B,
                            `FAM_OP_EX4B, `FAM_OP_EQPI, `FAM_OP_RSTEN,
                            `FAM_OP_RST:
                                pendOk_r <= 1'b1;
                            `FAM_OP_XQPI:
                                pendOk_r <= quadCommandMode;
                            default: ;
                        endcase
                    end
                end
                S_ADDR: begin
                    sh_r <= shNx;
                    cnt_r <= cntNx;
                    if (cntNx == addrBits) begin
                        cnt_r <= 6'h0;
                        state_r <= fast_r ? S_DUMMY : S_DATA;
                        memRead <= 1'b1;
                        if (need32_r)
                            memAddr <= shNx;
                        else
                            memAddr <= {extAddrByte, shNx[23:0]};
                        if (addressWidthStatus && need32_r)
                            extAddrByte <= shNx[31:24];
                    end
                end
                S_DUMMY: begin
                    cnt_r <= cntNx;
                    if (cntNx == dmyBits)
                        state_r <= S_DATA;
                end
                S_WDAT: begin
                    if (cnt_r == `FAM_BITS_OP) begin
                        state_r <= S_HOLD; // Too many bits: drop it
                        pendOk_r <= 1'b0;
                    end else begin
                        sh_r <= shNx;
                        cnt_r <= cntNx;
                    end
                end
                S_HOLD: pendOk_r <= 1'b0; // Extra clocks void the op
                default: ;
            endcase
        end else if (sFall && state_r == S_DATA) begin
            // Array data must follow memAddr before the next falling link clock edge;
            // no prefetch, so a slow array limits the link clock.
            // Wrap setting is only stored, not applied here.
            // New byte fetched when the previous one ran out
            ioOut <= laneBits(quadCommandMode, byteV);
            ioOe <= quadCommandMode ? 4'hF : 4'h2;
            outSh_r <= quadCommandMode ? {byteV[3:0], 4'h0} :
                {byteV[6:0], 1'b0};
            if (outCnt_r == 3'h0) begin
                outCnt_r <= quadCommandMode ? 3'h1 : 3'h7;
                if (!rdExt_r)
                    memAddr <= memAddr + 32'h1;
            end else begin
                outCnt_r <= outCnt_r - 3'h1;
            end
        end
    end
end

endmodule // fam_flash_front

/* File: tb/fam_flash_front_properties.sv */
`timescale 1ns/1ps
module fam_flash_front_properties #(parameter RST_CYC = 7500) (
    input logic ref_clk,
    input logic rst_n,
    input logic csN,
    input logic [3:0] ioOe,
    input logic [31:0] memAddr,
    input logic memRead,
    input logic quadEnableBit,
    input logic operationInProgress,
    input logic writeEnableLatch,
    input logic addressWidthStatus,
    input logic quadCommandMode,
    input logic [7:0] extAddrByte,
    input logic [2:0] wrapSettingBits,
    input logic [7:0] continuousReadModeBits,
    input logic softResetPulse,
    input logic resetBusy
);
    logic [15:0] busyCnt_r;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) busyCnt_r <= 16'h0000;
        else busyCnt_r <= resetBusy ? busyCnt_r + 16'h0001 : 16'h0000;
    end
    chk_reset_clears: assert property (
        softResetPulse |=> extAddrByte == 8'h00 && !writeEnableLatch &&
        wrapSettingBits == 3'h0 && continuousReadModeBits == 8'h00)
        else $error("soft reset left state");
    chk_busy_start: assert property (
        softResetPulse |=> resetBusy)
        else $error("no busy after reset");
    chk_busy_len: assert property (busyCnt_r <= RST_CYC + 1)
        else $error("busy too long");
    chk_busy_refuse: assert property (
        resetBusy |-> !$rose(writeEnableLatch) && !$rose(memRead))
        else $error("instruction taken while busy");
    chk_quad_gate: assert property (
        $rose(quadCommandMode) |-> quadEnableBit)
        else $error("quad mode without enable");
    chk_mode_keep: assert property (
        $changed(quadCommandMode) && !softResetPulse &&
        !$past(softResetPulse) |->
        $stable(writeEnableLatch) && $stable(wrapSettingBits))
        else $error("mode switch changed state");
    chk_read_block: assert property (
        operationInProgress |-> !$rose(memRead))
        else $error("read while busy");
    chk_ext_follow: assert property (
        $rose(memRead) && addressWidthStatus |=>
        extAddrByte == memAddr[31:24])
        else $error("extended byte not updated");
    chk_oe_idle: assert property (csN[*6] |-> ioOe == 4'h0)
        else $error("driving while deselected");
    chk_oe_lanes: assert property (
        ioOe != 4'h0 |-> ioOe == (quadCommandMode ? 4'hF : 4'h2))
        else $error("wrong lanes driven");
    cover property (softResetPulse);
    cover property ($rose(quadCommandMode));
    cover property ($rose(memRead) && addressWidthStatus);
endmodule // fam_flash_front_properties
bind fam_flash_front fam_flash_front_properties #(.RST_CYC(RST_CYC)) uChk (.*);

/* File: tb/fam_host_model.sv */
`timescale 1ns/1ps
module fam_host_model (
    input logic refClk,
    input logic [3:0] ioOut,
    output logic sclk,
    output logic csN,
    output logic [3:0] ioIn
);
    initial begin
        sclk = 1'b0;
        csN = 1'b1;
        ioIn = 4'h0;
    end
    // Half sclk period is four ref_clk cycles
    task tick;
        repeat (4) @(posedge refClk);
        #1;
    endtask
    task automatic xfer(input bit q, input logic [7:0] op,
        input logic [31:0] ov, input int nOut, input int nIn,
        output logic [31:0] iv);
        logic [39:0] sh;
        int w;
        sh = {op, ov << (32 - nOut)};
        w = q ? 4 : 1;
        iv = 32'h0;
        tick();
        csN = 1'b0;
        for (int i = 0; i < 8 + nOut; i += w) begin
            if (q) ioIn = sh[39:36];
            else ioIn[0] = sh[39];
            sh = sh << w;
            tick();
            sclk = 1'b1;
            tick();
            sclk = 1'b0;
        end
        for (int i = 0; i < nIn; i += w) begin
            tick();
            sclk = 1'b1;
            iv = (iv << w) | (q ? ioOut : ioOut[1]);
            tick();
            sclk = 1'b0;
        end
        // Released lines must not keep looking valid
        ioIn = ~ioIn;
        tick();
        csN = 1'b1;
        repeat (3) tick();
    endtask
endmodule // fam_host_model

/* File: tb/testbench.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin nCompared++; if ((a) !== (b)) begin mismatches++; \
    $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
module testbench;
    logic refClk = 0, rstN = 0, sclk, csN, qe = 0, opBusy = 0, sawOe = 0;
    logic wrapLd = 0, modeLd = 0, inQ = 0;
    logic [2:0] wrapIn = 0;
    logic [7:0] modeIn = 0, ext;
    logic [3:0] ioIn, ioOut, ioOe;
    logic [31:0] memAddr, r;
    logic memRead, write_enable_latch, address_width_status, quad, srp, busy;
    logic [2:0] wrap;
    logic [7:0] mbits;
    int mismatches = 0, nCompared = 0, cyc = 0;
    wire [7:0] memData = memAddr[7:0] ^ memAddr[31:24] ^ 8'h3C;
    always #20 refClk = ~refClk;
    fam_flash_front #(.RST_CYC(400)) dut (.ref_clk(refClk), .rst_n(rstN),
        .sclk(sclk), .csN(csN), .ioIn(ioIn), .ioOut(ioOut), .ioOe(ioOe),
        .memAddr(memAddr), .memRead(memRead), .memData(memData),
        .quadEnableBit(qe), .operationInProgress(opBusy), .welClear(1'b0),
        .wrapLoad(wrapLd), .wrapIn(wrapIn), .modeBitsLoad(modeLd),
        .modeBitsIn(modeIn), .writeEnableLatch(write_enable_latch),
        .addressWidthStatus(address_width_status), .quadCommandMode(quad),
        .extAddrByte(ext), .wrapSettingBits(wrap),
        .continuousReadModeBits(mbits), .softResetPulse(srp),
        .resetBusy(busy));
    fam_host_model host (.refClk(refClk), .ioOut(ioOut), .sclk(sclk),
        .csN(csN), .ioIn(ioIn));
    function automatic logic [7:0] f(input logic [31:0] a);
        return a[7:0] ^ a[31:24] ^ 8'h3C;
    endfunction
    task cmd(input logic [7:0] op);
        host.xfer(inQ, op, 32'h0, 0, 0, r);
    endtask
    task summarize;
        $display("compared %0d mismatches %0d", nCompared, mismatches);
        if (mismatches == 0 && nCompared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    always @(posedge refClk) begin
        if (ioOe !== 4'h0) sawOe <= 1'b1;
        cyc++;
        if (cyc > 40000) begin
            mismatches++;
            summarize();
        end
    end
    initial begin
        repeat (4) @(posedge refClk);
        #1 rstN = 1;
        repeat (4) @(posedge refClk);
        `CHK({ext, quad, address_width_status, write_enable_latch}, 11'h000)
        host.xfer(0, 8'hC5, 32'hA5, 8, 0, r);
        `CHK(ext, 8'h00)
        cmd(8'h06);
        `CHK(write_enable_latch, 1'b1)
        host.xfer(0, 8'hC5, 32'hA5, 8, 0, r);
        host.xfer(0, 8'hC8, 32'h0, 0, 16, r);
        `CHK(r[15:0], 16'hA5A5)
        host.xfer(0, 8'h03, 32'h10, 24, 16, r);
        `CHK(r[15:0], {f(32'hA5000010), f(32'hA5000011)})
        opBusy = 1;
        sawOe = 0;
        host.xfer(0, 8'h03, 32'h10, 24, 8, r);
        `CHK(sawOe, 1'b0)
        opBusy = 0;
        cmd(8'hB7);
        `CHK(address_width_status, 1'b1)
        host.xfer(0, 8'h03, 32'h12000020, 32, 8, r);
        `CHK({ext, r[7:0]}, {8'h12, f(32'h12000020)})
        cmd(8'hE9);
        `CHK(address_width_status, 1'b0)
        host.xfer(0, 8'hC8, 32'h0, 0, 8, r);
        `CHK(r[7:0], 8'h12)
        host.xfer(0, 8'h13, 32'h34000040, 32, 8, r);
        `CHK(r[7:0], f(32'h34000040))
        host.xfer(0, 8'h0B, 32'h5000, 32, 8, r);
        `CHK(r[7:0], f(32'h12000050))
        @(posedge refClk);
        #1 {wrapLd, modeLd, wrapIn, modeIn} = {2'b11, 3'h5, 8'h5A};
        @(posedge refClk);
        #1 {wrapLd, modeLd} = 2'b00;
        cmd(8'h06);
        cmd(8'h38);
        `CHK(quad, 1'b0)
        qe = 1;
        cmd(8'h38);
        `CHK({quad, write_enable_latch, wrap}, 5'h1D)
        inQ = 1;
        sawOe = 0;
        host.xfer(1, 8'h13, 32'h40, 32, 8, r);
        `CHK(sawOe, 1'b0)
        host.xfer(1, 8'hC8, 32'h0, 0, 8, r);
        `CHK(r[7:0], 8'h12)
        cmd(8'hFF);
        inQ = 0;
        `CHK({quad, write_enable_latch, wrap}, 5'h0D)
        cmd(8'h66);
        cmd(8'h04);
        cmd(8'h99);
        `CHK(ext, 8'h12)
        cmd(8'h06);
        `CHK(write_enable_latch, 1'b1)
        cmd(8'h66);
        cmd(8'h99);
        `CHK({busy, ext, write_enable_latch, wrap, mbits}, 21'h100000)
        cmd(8'h06);
        `CHK(write_enable_latch, 1'b0)
        for (int i = 0; i < 600 && busy !== 1'b0; i++) @(posedge refClk);
        cmd(8'h06);
        `CHK(write_enable_latch, 1'b1)
        summarize();
    end
endmodule // testbench
